// >>> src/pdrx_consts.svh
// Offsets, field positions, reset values and timing counts of the receive control registers
`ifndef PDRX_CONSTS_SVH
`define PDRX_CONSTS_SVH

// Register indices; byte address is four times the index
`define PDRX_IDX_ACK_TIMEOUT   14'h1A46
`define PDRX_IDX_BAD_COUNT     14'h1A47
`define PDRX_IDX_REPEAT_COUNT  14'h1A48
`define PDRX_IDX_HR_WINDOW     14'h1A49
`define PDRX_IDX_ACK_UPPER     14'h1A4A
`define PDRX_IDX_ACK_LOWER     14'h1A4B
`define PDRX_IDX_ID_HELD       14'h1A4C
`define PDRX_IDX_LENGTH_LIMIT  14'h1A4D
`define PDRX_IDX_READ_POINTER  14'h1A50
`define PDRX_IDX_POINTER_CTL   14'h1A51
`define PDRX_IDX_RESET_CONTROL_REGISTER     14'h1A60
`define PDRX_IDX_MODE_CTL      14'h1A61
`define PDRX_IDX_IRQ_STATUS    14'h1A62
`define PDRX_IDX_IRQ_MASK      14'h1A63

// Reset values
`define PDRX_RST_ACK_TIMEOUT   8'h64
`define PDRX_RST_HR_WINDOW     7'h5E
`define PDRX_RST_LENGTH_LIMIT  8'h22

// Field positions
`define PDRX_RESET_SW_BIT      0
`define PDRX_RESET_PROTO_BIT   1
`define PDRX_MODE_AUTO_RESP    0
`define PDRX_MODE_AUTO_RETRY   1
`define PDRX_MODE_BIST_RX      2
`define PDRX_PTRCTL_EMPTY      7
`define PDRX_PTRCTL_AT_TOP     1
`define PDRX_PTRCTL_WRAP       0
`define PDRX_IRQ_DEBUG         0
`define PDRX_IRQ_BAD_PACKET    1
`define PDRX_IRQ_OVERSIZE      2
`define PDRX_IRQ_ACK_TIMEOUT   3
`define PDRX_IRQ_DUPLICATE     4
`define PDRX_IRQ_WIDTH         5

// Queue geometry and counter limits
`define PDRX_QUEUE_TOP         7'h7F
`define PDRX_COUNT_MAX         8'hFF

// Timing: clock period, tick period, timeout unit
`define PDRX_CLK_PERIOD_NS     5
`define PDRX_TICK_NS           1000
`define PDRX_TICK_CYCLES       (`PDRX_TICK_NS / `PDRX_CLK_PERIOD_NS)
`define PDRX_TIMEOUT_UNIT_US   10

`endif

// >>> src/pdrx_pkg.sv
// Types shared by the receive control register block
package pdrx_pkg;

   typedef struct packed {
      logic [2:0]  sop_type;
      logic [2:0]  msg_id;
      logic [7:0]  length;
      logic        crc_bad;
      logic        eop_bad;
      logic        sym_err;
      logic        is_ack;
      logic [15:0] ack_header;
   } pdrx_packet_t;

   typedef struct packed {
      logic accept;
      logic drop;
      logic duplicate;
      logic oversize;
   } pdrx_verdict_t;

   typedef enum logic {
      ACK_IDLE,
      ACK_WAIT
   } pdrx_ack_state_t;

endpackage

// >>> src/pdrx_regs.sv
// Receive control and status registers of a power delivery MAC, with APB slave
// Behaviour
// - Ack wait timeout equals field times ten microseconds; resets to one millisecond.
// - Zero timeout is invalid and unchecked; software must not program it.
// - Timeout counts a free-running 1 us tick, so may run 1 us short.
// - Bad packet counter counts valid-start packets with bad CRC, EOP or symbol.
// - Bad packet count above 127 sets the debug threshold flag.
// - Any write to either counter clears that counter.
// - Packets during self-test receive mode are not counted as bad.
// - With auto response, duplicates are counted; above 127 sets debug flag.
// - Hard reset window is seven bits in bit times, reset 1011110b.
// - In auto-retry mode last ack message bytes are captured, not queued.
// - Five held-ID flags, one per start-of-packet type, bits 0 to 4.
// - Writing one to a held flag clears it; next packet is no duplicate.
// - Software or protocol reset command clears all held-ID flags.
// - Length limit includes four CRC bytes and resets to 22h.
// - Read pointer is writable so software can skip a packet.
// - Pointer writes are held and moved live on a control bits write.
// - Oversize packets are dropped, flagged and raise the bad packet interrupt.
// - Queue spans 0 to 127; wrap flag toggles on wrap, software keeps it.
`include "pdrx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pdrx_regs (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 clk_en,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [15:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 pkt_valid,
   input  wire pdrx_pkg::pdrx_packet_t pkt,
   output pdrx_pkg::pdrx_verdict_t   verdict,
   input  wire logic                 ack_wait_start,
   input  wire logic                 ack_seen,
   output logic                      ack_timeout,
   input  wire logic                 queue_advance,
   input  wire logic [6:0]           write_head_pointer,
   input  wire logic                 write_head_wrap,
   output logic      [6:0]           queue_read_pointer,
   output logic      [6:0]           hard_reset_window_bits,
   output logic                      irq
);

   function automatic logic [15:0] addr_of(input logic [13:0] idx);
      addr_of = {idx, 2'b00};
   endfunction

   // Bus decode
   wire logic access  = psel && penable;
   wire logic wr      = access && pwrite && pstrb[0] && clk_en;
   wire logic hit_to  = paddr == addr_of(`PDRX_IDX_ACK_TIMEOUT);
   wire logic hit_bad = paddr == addr_of(`PDRX_IDX_BAD_COUNT);
   wire logic hit_rep = paddr == addr_of(`PDRX_IDX_REPEAT_COUNT);
   wire logic hit_hr  = paddr == addr_of(`PDRX_IDX_HR_WINDOW);
   wire logic hit_up  = paddr == addr_of(`PDRX_IDX_ACK_UPPER);
   wire logic hit_lo  = paddr == addr_of(`PDRX_IDX_ACK_LOWER);
   wire logic hit_id  = paddr == addr_of(`PDRX_IDX_ID_HELD);
   wire logic hit_len = paddr == addr_of(`PDRX_IDX_LENGTH_LIMIT);
   wire logic hit_rp  = paddr == addr_of(`PDRX_IDX_READ_POINTER);
   wire logic hit_pc  = paddr == addr_of(`PDRX_IDX_POINTER_CTL);
   wire logic hit_rc  = paddr == addr_of(`PDRX_IDX_RESET_CONTROL_REGISTER);
   wire logic hit_md  = paddr == addr_of(`PDRX_IDX_MODE_CTL);
   wire logic hit_is  = paddr == addr_of(`PDRX_IDX_IRQ_STATUS);
   wire logic hit_im  = paddr == addr_of(`PDRX_IDX_IRQ_MASK);
   wire logic mapped  = hit_to | hit_bad | hit_rep | hit_hr | hit_up | hit_lo | hit_id
                      | hit_len | hit_rp | hit_pc | hit_rc | hit_md | hit_is | hit_im;

   // Registers
   logic [7:0]                    ack_wait_timeout;
   logic [7:0]                    bad_packet_count;
   logic [7:0]                    repeat_packet_count;
   logic [7:0]                    last_ack_upper;
   logic [7:0]                    last_ack_lower;
   logic [4:0]                    message_id_held;
   logic [2:0]                    held_id [5];
   logic [7:0]                    length_limit;
   logic [6:0]                    hard_reset_window;
   logic [6:0]                    pointer_hold;
   logic                          pointer_wrap;
   logic [2:0]                    mode;
   logic [`PDRX_IRQ_WIDTH-1:0]    irq_status;
   logic [`PDRX_IRQ_WIDTH-1:0]    irq_mask;
   logic [7:0]                    tick_div;
   logic                          tick;
   logic [11:0]                   ack_elapsed;
   pdrx_pkg::pdrx_ack_state_t     ack_state;
   logic [11:0]                   ack_wait_cycles;

   // Packet classification
   wire logic auto_resp   = mode[`PDRX_MODE_AUTO_RESP];
   wire logic auto_retry  = mode[`PDRX_MODE_AUTO_RETRY];
   wire logic bist_rx     = mode[`PDRX_MODE_BIST_RX];
   wire logic pkt_in      = pkt_valid && clk_en;
   wire logic pkt_faulty  = pkt.crc_bad || pkt.eop_bad || pkt.sym_err;
   wire logic oversize    = pkt.length > length_limit;
   wire logic sop_ok      = pkt.sop_type < 3'd5;
   wire logic held_match  = sop_ok && message_id_held[pkt.sop_type]
                          && held_id[pkt.sop_type] == pkt.msg_id;
   wire logic bad_event   = pkt_in && pkt_faulty && !oversize && !bist_rx;
   wire logic good_pkt    = pkt_in && !pkt_faulty && !oversize;
   wire logic dup_event   = good_pkt && auto_resp && !pkt.is_ack && held_match;
   wire logic store_id    = good_pkt && auto_resp && !pkt.is_ack && sop_ok && !held_match;
   wire logic ack_capture = good_pkt && auto_retry && pkt.is_ack;
   wire logic proto_reset = wr && hit_rc
                          && (pwdata[`PDRX_RESET_SW_BIT] || pwdata[`PDRX_RESET_PROTO_BIT]);

   // Counters: a write clears; an event in the same cycle still counts once
   wire logic [7:0] bad_base = (wr && hit_bad) ? 8'h00 : bad_packet_count;
   wire logic [7:0] rep_base = (wr && hit_rep) ? 8'h00 : repeat_packet_count;
   wire logic [7:0] next_bad = (bad_event && bad_base != `PDRX_COUNT_MAX)
                             ? bad_base + 8'h01 : bad_base;
   wire logic [7:0] next_rep = (dup_event && rep_base != `PDRX_COUNT_MAX)
                             ? rep_base + 8'h01 : rep_base;

   // Read pointer, hardware advance wraps at the top of the queue
   wire logic       ptr_at_top  = queue_read_pointer == `PDRX_QUEUE_TOP;
   wire logic       queue_empty = queue_read_pointer == write_head_pointer
                                && pointer_wrap == write_head_wrap;
   wire logic       load_ptr    = wr && hit_pc;

   // Timeout target in microseconds
   wire logic [11:0] ack_target = 12'(ack_wait_timeout) * 12'(`PDRX_TIMEOUT_UNIT_US);
   wire logic        ack_expire = ack_state == pdrx_pkg::ACK_WAIT && !ack_seen
                                && tick && ack_elapsed + 12'd1 >= ack_target;

   // Interrupt events; set wins over a write-one clear
   wire logic [`PDRX_IRQ_WIDTH-1:0] irq_set;
   assign irq_set[`PDRX_IRQ_DEBUG]       = next_bad[7] || next_rep[7];
   assign irq_set[`PDRX_IRQ_BAD_PACKET]  = bad_event || (pkt_in && oversize);
   assign irq_set[`PDRX_IRQ_OVERSIZE]    = pkt_in && oversize;
   assign irq_set[`PDRX_IRQ_ACK_TIMEOUT] = ack_expire && clk_en;
   assign irq_set[`PDRX_IRQ_DUPLICATE]   = dup_event;
   wire logic [`PDRX_IRQ_WIDTH-1:0] irq_clr = (wr && hit_is)
                                            ? pwdata[`PDRX_IRQ_WIDTH-1:0] : '0;

   assign irq    = |(irq_status & irq_mask);
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign hard_reset_window_bits = hard_reset_window;

   // Free-running microsecond tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_div <= 8'h00;
         tick     <= 1'b0;
      end else if (clk_en) begin
         tick     <= tick_div == 8'(`PDRX_TICK_CYCLES - 1);
         tick_div <= (tick_div == 8'(`PDRX_TICK_CYCLES - 1)) ? 8'h00 : tick_div + 8'h01;
      end
   end

   // Ack wait timer; zero setting is not guarded, it expires on the first tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_state   <= pdrx_pkg::ACK_IDLE;
         ack_elapsed <= 12'h000;
         ack_timeout <= 1'b0;
      end else if (clk_en) begin
         ack_timeout <= ack_expire;
         unique case (ack_state)
            pdrx_pkg::ACK_IDLE: begin
               ack_elapsed <= 12'h000;
               if (ack_wait_start) ack_state <= pdrx_pkg::ACK_WAIT;
            end
            pdrx_pkg::ACK_WAIT: begin
               if (ack_seen || ack_expire) ack_state <= pdrx_pkg::ACK_IDLE;
               else if (tick) ack_elapsed <= ack_elapsed + 12'd1;
            end
         endcase
      end
   end

   // Cycles spent waiting; restarts on a setting write, so a shortened wait keeps the bound
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_wait_cycles <= 12'h000;
      end else if (clk_en) begin
         if (ack_state == pdrx_pkg::ACK_IDLE || (wr && hit_to)) ack_wait_cycles <= 12'h000;
         else if (ack_wait_cycles != 12'hFFF) ack_wait_cycles <= ack_wait_cycles + 12'h001;
      end
   end

   // Software-written configuration
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_wait_timeout  <= `PDRX_RST_ACK_TIMEOUT;
         hard_reset_window <= `PDRX_RST_HR_WINDOW;
         length_limit      <= `PDRX_RST_LENGTH_LIMIT;
         mode              <= 3'h0;
         irq_mask          <= '0;
      end else if (wr) begin
         if (hit_to)  ack_wait_timeout  <= pwdata[7:0];
         if (hit_hr)  hard_reset_window <= pwdata[6:0];
         if (hit_len) length_limit      <= pwdata[7:0];
         if (hit_md)  mode              <= pwdata[2:0];
         if (hit_im)  irq_mask          <= pwdata[`PDRX_IRQ_WIDTH-1:0];
      end
   end

   // Counters and status
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bad_packet_count    <= 8'h00;
         repeat_packet_count <= 8'h00;
         irq_status          <= '0;
         last_ack_upper      <= 8'h00;
         last_ack_lower      <= 8'h00;
      end else if (clk_en) begin
         bad_packet_count    <= next_bad;
         repeat_packet_count <= next_rep;
         irq_status          <= (irq_status & ~irq_clr) | irq_set;
         if (ack_capture) begin
            last_ack_upper <= pkt.ack_header[15:8];
            last_ack_lower <= pkt.ack_header[7:0];
         end
      end
   end

   // Held message IDs, one slot per start-of-packet type
   generate
      for (genvar i = 0; i < 5; i++) begin : g_held
         wire logic clr_i = (wr && hit_id && pwdata[i]) || proto_reset;
         wire logic set_i = store_id && pkt.sop_type == 3'(i);
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               message_id_held[i] <= 1'b0;
               held_id[i]         <= 3'h0;
            end else if (clk_en) begin
               if (set_i) begin
                  message_id_held[i] <= 1'b1;
                  held_id[i]         <= pkt.msg_id;
               end else if (clr_i) begin
                  message_id_held[i] <= 1'b0;
                  held_id[i]         <= 3'h0;
               end
            end
         end
      end
   endgenerate

   // Read pointer with coherent staging
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pointer_hold       <= 7'h00;
         queue_read_pointer <= 7'h00;
         pointer_wrap       <= 1'b0;
      end else if (clk_en) begin
         if (wr && hit_rp) pointer_hold <= pwdata[6:0];
         if (load_ptr) begin
            queue_read_pointer <= pointer_hold;
            pointer_wrap       <= pwdata[`PDRX_PTRCTL_WRAP];
         end else if (queue_advance) begin
            queue_read_pointer <= queue_read_pointer + 7'h01;
            if (ptr_at_top) pointer_wrap <= ~pointer_wrap;
         end
      end
   end

   // Verdict to the receive path, registered
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         verdict <= '0;
      end else if (clk_en) begin
         verdict.accept    <= good_pkt && !dup_event && !ack_capture;
         verdict.drop      <= pkt_in && (oversize || dup_event);
         verdict.duplicate <= dup_event;
         verdict.oversize  <= pkt_in && oversize;
      end
   end

   // Read data, registered off the access phase would add a wait; kept combinational
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         unique case (1'b1)
            hit_to:  prdata[7:0] = ack_wait_timeout;
            hit_bad: prdata[7:0] = bad_packet_count;
            hit_rep: prdata[7:0] = repeat_packet_count;
            hit_hr:  prdata[6:0] = hard_reset_window;
            hit_up:  prdata[7:0] = last_ack_upper;
            hit_lo:  prdata[7:0] = last_ack_lower;
            hit_id:  prdata[4:0] = message_id_held;
            hit_len: prdata[7:0] = length_limit;
            hit_rp:  prdata[6:0] = queue_read_pointer;
            hit_pc:  prdata[7:0] = {queue_empty, 5'h00, ptr_at_top, pointer_wrap};
            hit_md:  prdata[2:0] = mode;
            hit_is:  prdata[`PDRX_IRQ_WIDTH-1:0] = irq_status;
            hit_im:  prdata[`PDRX_IRQ_WIDTH-1:0] = irq_mask;
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   bad_count_step_a: assert property (clk_en && bad_event && !(wr && hit_bad)
      && bad_packet_count < 8'hFF |=> bad_packet_count == $past(bad_packet_count) + 8'h01)
      else $error("bad packet counter did not step");
   bist_no_count_a: assert property (clk_en && bist_rx && !(wr && hit_bad)
      |=> bad_packet_count == $past(bad_packet_count))
      else $error("bad packet counted in self-test mode");
   counter_clear_a: assert property (wr && hit_rep && !dup_event
      |=> repeat_packet_count == 8'h00)
      else $error("repeat counter not cleared by write");
   debug_flag_a: assert property (clk_en && bad_packet_count[7]
      |=> irq_status[`PDRX_IRQ_DEBUG])
      else $error("debug flag missing above 127");
   held_clear_a: assert property (proto_reset && !store_id
      |=> message_id_held == 5'h00)
      else $error("held flags survive reset command");
   pointer_stage_a: assert property (wr && hit_rp && !load_ptr && !queue_advance
      |=> queue_read_pointer == $past(queue_read_pointer))
      else $error("pointer moved before control write");
   oversize_drop_a: assert property (pkt_in && oversize
      |=> verdict.drop && verdict.oversize && irq_status[`PDRX_IRQ_BAD_PACKET])
      else $error("oversize packet not dropped");
   ack_timeout_a: assert property (ack_wait_timeout == 8'h01
      && ack_state == pdrx_pkg::ACK_WAIT |-> ack_wait_cycles < 12'h7D0)
      else $error("ack wait did not expire in time");
   wrap_toggle_a: assert property (clk_en && queue_advance && !load_ptr && ptr_at_top
      |=> queue_read_pointer == 7'h00 && pointer_wrap != $past(pointer_wrap))
      else $error("wrap flag not toggled at top");
   ack_capture_a: assert property (ack_capture
      |=> {last_ack_upper, last_ack_lower} == $past(pkt.ack_header))
      else $error("last ack bytes not captured");
   held_set_a: assert property (store_id
      |=> message_id_held[$past(pkt.sop_type)])
      else $error("held flag not set on store");
   repeat_gate_a: assert property (clk_en && !auto_resp && !(wr && hit_rep)
      |=> repeat_packet_count == $past(repeat_packet_count))
      else $error("repeat counted outside auto response");

endmodule // pdrx_regs

`default_nettype wire

// >>> test/pdrx_partner.sv
// Port partner model: hands received packets to the block; holds ack_seen low
`timescale 1ns/1ps
`default_nettype none

module pdrx_partner (
   input  wire logic              sys_clk,
   output logic                   pkt_valid,
   output pdrx_pkg::pdrx_packet_t pkt,
   output logic                   ack_seen
);
   initial begin
      pkt_valid = 1'b0;
      pkt = '0;
      ack_seen = 1'b0;
   end

   // One packet per call; fields flip afterwards so a stale packet never looks valid
   task automatic send(input pdrx_pkg::pdrx_packet_t p);
      @(posedge sys_clk);
      pkt_valid <= 1'b1;
      pkt <= p;
      @(posedge sys_clk);
      pkt_valid <= 1'b0;
      pkt <= ~p;
   endtask
endmodule // pdrx_partner

`default_nettype wire

// >>> test/test_pd_rx_control_registers.sv
// Self-checking bench for the receive control registers
`include "pdrx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module test_pd_rx_control_registers;
   logic                    sys_clk, rst, clk_en, psel, penable, pwrite;
   logic [15:0]             paddr;
   logic [31:0]             pwdata, prdata, rdat;
   logic [3:0]              pstrb;
   logic                    pready, pslverr, rerr, pkt_valid, ack_seen, ack_wait_start;
   logic                    ack_timeout, queue_advance, write_head_wrap, irq;
   pdrx_pkg::pdrx_packet_t  pkt;
   pdrx_pkg::pdrx_verdict_t verdict;
   logic [6:0]              write_head_pointer, queue_read_pointer, hard_reset_window_bits;
   int                      error_cnt, samples_checked, n;
   logic [13:0]             ri [9];
   logic [31:0]             rv [9];

   pdrx_regs dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
      .pkt(pkt), .verdict(verdict), .ack_wait_start(ack_wait_start), .ack_seen(ack_seen),
      .ack_timeout(ack_timeout), .queue_advance(queue_advance),
      .write_head_pointer(write_head_pointer), .write_head_wrap(write_head_wrap),
      .queue_read_pointer(queue_read_pointer),
      .hard_reset_window_bits(hard_reset_window_bits), .irq(irq));
   pdrx_partner p_u (.sys_clk(sys_clk), .pkt_valid(pkt_valid), .pkt(pkt),
      .ack_seen(ack_seen));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Zero wait states are the designer's choice, so the wait is still bounded, not assumed
   task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write land before callers look at outputs
      #1;
      if (k >= 50) begin
         error_cnt++;
         finish_test();
      end
   endtask

   task automatic rdc(input logic [13:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk($sformatf("reg %h", idx), exp, rdat);
   endtask

   // Verdict is checked only when expected differs from the don't-care code F
   task automatic snd(input logic [2:0] s, input logic [2:0] id, input logic [7:0] len,
                      input logic [2:0] e, input logic a, input logic [15:0] h,
                      input logic [3:0] ev);
      p_u.send({s, id, len, e, a, h});
      #1;
      if (ev != 4'hF) chk("verdict", {28'h0, ev}, {28'h0, verdict});
   endtask

   initial begin
      {rst, clk_en, pstrb} = {1'b1, 1'b1, 4'hF};
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ack_wait_start, queue_advance, write_head_wrap} = '0;
      write_head_pointer = 7'h05;
      {error_cnt, samples_checked} = '0;
      ri = '{`PDRX_IDX_ACK_TIMEOUT, `PDRX_IDX_BAD_COUNT, `PDRX_IDX_REPEAT_COUNT,
             `PDRX_IDX_HR_WINDOW, `PDRX_IDX_ACK_UPPER, `PDRX_IDX_ACK_LOWER,
             `PDRX_IDX_ID_HELD, `PDRX_IDX_LENGTH_LIMIT, `PDRX_IDX_READ_POINTER};
      rv = '{32'h64, 32'h0, 32'h0, 32'h5E, 32'h0, 32'h0, 32'h0, 32'h22, 32'h0};
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) rdc(ri[i], rv[i]);
      apb(1'b0, 14'h1A70, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
      for (int i = 0; i < 3; i++) snd(3'h0, 3'h0, 8'h08, 3'h4 >> i, 1'b0, 16'h0, 4'hF);
      rdc(`PDRX_IDX_BAD_COUNT, 32'h03);
      apb(1'b1, `PDRX_IDX_MODE_CTL, 32'h04);
      snd(3'h0, 3'h0, 8'h08, 3'h4, 1'b0, 16'h0, 4'hF);
      rdc(`PDRX_IDX_BAD_COUNT, 32'h03);
      apb(1'b1, `PDRX_IDX_MODE_CTL, 32'h00);
      apb(1'b1, `PDRX_IDX_BAD_COUNT, 32'h5A);
      rdc(`PDRX_IDX_BAD_COUNT, 32'h00);
      for (int i = 0; i < 128; i++) snd(3'h0, 3'h0, 8'h08, 3'h1, 1'b0, 16'h0, 4'hF);
      rdc(`PDRX_IDX_BAD_COUNT, 32'h80);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `PDRX_IDX_IRQ_MASK, 32'h01);
      chk("irq debug", 32'h1, {31'h0, irq});
      apb(1'b1, `PDRX_IDX_BAD_COUNT, 32'h00);
      apb(1'b1, `PDRX_IDX_IRQ_STATUS, 32'h1F);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, `PDRX_IDX_IRQ_MASK, 32'h04);
      snd(3'h0, 3'h0, 8'h23, 3'h0, 1'b0, 16'h0, 4'h5);
      apb(1'b0, `PDRX_IDX_IRQ_STATUS, 32'h0);
      chk("oversize status", 32'h6, rdat & 32'h6);
      chk("irq oversize", 32'h1, {31'h0, irq});
      snd(3'h0, 3'h0, 8'h22, 3'h0, 1'b0, 16'h0, 4'h8);
      apb(1'b1, `PDRX_IDX_IRQ_STATUS, 32'h1F);
      apb(1'b1, `PDRX_IDX_MODE_CTL, 32'h01);
      snd(3'h1, 3'h3, 8'h08, 3'h0, 1'b0, 16'h0, 4'h8);
      rdc(`PDRX_IDX_ID_HELD, 32'h02);
      for (int i = 0; i < 128; i++) snd(3'h1, 3'h3, 8'h08, 3'h0, 1'b0, 16'h0, 4'h6);
      rdc(`PDRX_IDX_REPEAT_COUNT, 32'h80);
      apb(1'b0, `PDRX_IDX_IRQ_STATUS, 32'h0);
      chk("debug from repeats", 32'h1, rdat & 32'h1);
      apb(1'b1, `PDRX_IDX_REPEAT_COUNT, 32'hFF);
      rdc(`PDRX_IDX_REPEAT_COUNT, 32'h00);
      apb(1'b1, `PDRX_IDX_ID_HELD, 32'h02);
      rdc(`PDRX_IDX_ID_HELD, 32'h00);
      snd(3'h1, 3'h3, 8'h08, 3'h0, 1'b0, 16'h0, 4'h8);
      snd(3'h4, 3'h0, 8'h08, 3'h0, 1'b0, 16'h0, 4'h8);
      rdc(`PDRX_IDX_ID_HELD, 32'h12);
      apb(1'b1, `PDRX_IDX_RESET_CONTROL_REGISTER, 32'h02);
      rdc(`PDRX_IDX_ID_HELD, 32'h00);
      snd(3'h2, 3'h1, 8'h08, 3'h0, 1'b0, 16'h0, 4'h8);
      apb(1'b1, `PDRX_IDX_RESET_CONTROL_REGISTER, 32'h01);
      rdc(`PDRX_IDX_ID_HELD, 32'h00);
      apb(1'b1, `PDRX_IDX_MODE_CTL, 32'h02);
      snd(3'h0, 3'h5, 8'h06, 3'h0, 1'b1, 16'hA55A, 4'hF);
      rdc(`PDRX_IDX_ACK_UPPER, 32'hA5);
      rdc(`PDRX_IDX_ACK_LOWER, 32'h5A);
      apb(1'b1, `PDRX_IDX_HR_WINDOW, 32'hFF);
      rdc(`PDRX_IDX_HR_WINDOW, 32'h7F);
      chk("window port", 32'h7F, {25'h0, hard_reset_window_bits});
      @(posedge sys_clk);
      clk_en <= 1'b0;
      apb(1'b1, `PDRX_IDX_LENGTH_LIMIT, 32'h10);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rdc(`PDRX_IDX_LENGTH_LIMIT, 32'h22);
      apb(1'b1, `PDRX_IDX_READ_POINTER, 32'h7F);
      chk("pointer held", 32'h0, {25'h0, queue_read_pointer});
      apb(1'b1, `PDRX_IDX_POINTER_CTL, 32'h01);
      chk("pointer moved", 32'h7F, {25'h0, queue_read_pointer});
      rdc(`PDRX_IDX_POINTER_CTL, 32'h03);
      @(posedge sys_clk);
      queue_advance <= 1'b1;
      @(posedge sys_clk);
      queue_advance <= 1'b0;
      rdc(`PDRX_IDX_POINTER_CTL, 32'h00);
      apb(1'b1, `PDRX_IDX_READ_POINTER, 32'h05);
      apb(1'b1, `PDRX_IDX_POINTER_CTL, 32'h00);
      rdc(`PDRX_IDX_POINTER_CTL, 32'h80);
      apb(1'b1, `PDRX_IDX_ACK_TIMEOUT, 32'h01);
      apb(1'b1, `PDRX_IDX_IRQ_MASK, 32'h08);
      @(posedge sys_clk);
      ack_wait_start <= 1'b1;
      @(posedge sys_clk);
      ack_wait_start <= 1'b0;
      n = 0;
      // Free-running tick may cut up to one tick off ten
      while (ack_timeout !== 1'b1 && n < 2500) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("timeout in range", 32'h1, {31'h0, n >= 1790 && n <= 2005});
      chk("irq timeout", 32'h1, {31'h0, irq});
      finish_test();
   end
endmodule // test_pd_rx_control_registers

`default_nettype wire
